/* hw/pit_pkg.sv */
/*
  Shared constants of the prescaled interval timer: register indices,
  field positions, reset values and count clock select codes.
  Assumes nothing of its surroundings; every file using it writes pit_pkg::name.
*/
package pit_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Register indices; byte address is four times the index
  localparam logic [31:0] MODE_IDX   = 32'h0FFFF8B0;
  localparam logic [31:0] CMP_IDX    = 32'hFFFF8B1F;
  localparam logic [31:0] STATUS_IDX = 32'h0FFFF8B4;

  ////////////////////////////////////////////////////////////////////////////
  // Mode register fields
  localparam int          RUN_BIT      = 4;
  localparam int          GATE_OFF_BIT = 2;
  localparam int          SEL_HI_BIT   = 1;
  localparam int          SEL_LO_BIT   = 0;
  localparam logic [7:0]  MODE_MASK    = 8'h17;
  localparam logic [7:0]  MODE_RESET   = 8'h00;
  localparam logic [7:0]  CMP_RESET    = 8'h00;

  ////////////////////////////////////////////////////////////////////////////
  // Status register fields
  localparam int          STAT_RUN_BIT = 8;
  localparam int          STAT_WCLK_BIT = 9;

  ////////////////////////////////////////////////////////////////////////////
  // Counter values
  localparam logic [7:0]  CNT_STOPPED  = 8'h01;
  localparam logic [7:0]  CNT_CLEARED  = 8'h00;
  localparam logic [7:0]  CNT_STEP     = 8'h01;

  ////////////////////////////////////////////////////////////////////////////
  // Count clock select codes and prescaler masks
  localparam logic [1:0]  SEL_DIV1     = 2'h0;
  localparam logic [1:0]  SEL_DIV2     = 2'h1;
  localparam logic [1:0]  SEL_DIV4     = 2'h2;
  localparam logic [1:0]  SEL_DIV8     = 2'h3;
  localparam logic [2:0]  MASK_DIV1    = 3'h0;
  localparam logic [2:0]  MASK_DIV2    = 3'h1;
  localparam logic [2:0]  MASK_DIV4    = 3'h3;
  localparam logic [2:0]  MASK_DIV8    = 3'h7;
  localparam logic [2:0]  PRE_STEP     = 3'h1;
  localparam logic [2:0]  PRE_RESET    = 3'h0;

  ////////////////////////////////////////////////////////////////////////////
  // AXI responses
  localparam logic [1:0]  RESP_OKAY    = 2'h0;
  localparam logic [1:0]  RESP_SLVERR  = 2'h2;

endpackage

/* hw/pit_ctrl_if.sv */
/*
  Control carrier between the timer top and its prescaler and counter.
  Assumes the top drives the control fields from its registers.
*/
`timescale 1ns/10ps
interface pit_ctrl_if;
  logic       run;
  logic [1:0] sel;
  logic       gate_off;
  logic [7:0] cmp;
  logic       tick;

  modport ctrl (output run, sel, gate_off, cmp, input tick);
  modport pre  (input run, sel, output tick);
  modport cnt  (input run, gate_off, cmp, tick);
endinterface

/* hw/pit_prescaler.sv */
/*
  Three-stage prescaler and count clock selector of the interval timer.
  Assumes one clock sys_clk; the selected rate leaves as a one-cycle tick.
*/
`timescale 1ns/10ps
module pit_prescaler
(
  input  wire logic sys_clk,
  input  wire logic nrst,
  pit_ctrl_if.pre   bus
);

  logic [2:0] pre_reg;

  ////////////////////////////////////////////////////////////////////////////
  // Prescaler mask for each select code
  function automatic logic [2:0] sel_mask(input logic [1:0] sel);
    case (sel)
      pit_pkg::SEL_DIV1: sel_mask = pit_pkg::MASK_DIV1;
      pit_pkg::SEL_DIV2: sel_mask = pit_pkg::MASK_DIV2;
      pit_pkg::SEL_DIV4: sel_mask = pit_pkg::MASK_DIV4;
      default:           sel_mask = pit_pkg::MASK_DIV8;
    endcase
  endfunction

  // Prescaler runs only while the timer is on, else held cleared
  always_ff @(posedge sys_clk)
  begin
    if (!nrst || !bus.run)
      pre_reg <= pit_pkg::PRE_RESET;
    else
      pre_reg <= pre_reg + pit_pkg::PRE_STEP;
  end

  // Tick once per 1, 2, 4 or 8 main clocks
  assign bus.tick = bus.run && ((pre_reg & sel_mask(bus.sel)) == sel_mask(bus.sel));

endmodule

/* hw/pit_counter.sv */
/*
  Eight-bit interval counter with compare, interrupt pulse and the
  halved match-rate clock for the watch timer.
  Assumes ticks come from pit_prescaler on the same clock.
*/
`timescale 1ns/10ps
module pit_counter
(
  input  wire logic       sys_clk,
  input  wire logic       nrst,
  pit_ctrl_if.cnt         bus,
  output logic            irq,
  output logic            watch_clk,
  output logic [7:0]      count
);

  logic [7:0] cnt_reg;
  logic [7:0] cnt_next;
  logic       match;
  logic       irq_reg;
  logic       wclk_reg;

  // Match when the next value reaches compare; compare 00H wraps at 256
  assign cnt_next = cnt_reg + pit_pkg::CNT_STEP;
  assign match    = bus.tick && (cnt_next == bus.cmp);

  ////////////////////////////////////////////////////////////////////////////
  // Counter: held at 01H while stopped, cleared on match
  always_ff @(posedge sys_clk)
  begin
    if (!nrst || !bus.run)
      cnt_reg <= pit_pkg::CNT_STOPPED;
    else if (match)
      cnt_reg <= pit_pkg::CNT_CLEARED;
    else if (bus.tick)
      cnt_reg <= cnt_next;
  end

  // Interrupt request, one main clock per match
  always_ff @(posedge sys_clk)
  begin
    if (!nrst)
      irq_reg <= 1'b0;
    else
      irq_reg <= match;
  end

  // Watch clock toggles per match, low when stopped or gated off
  always_ff @(posedge sys_clk)
  begin
    if (!nrst || !bus.run || bus.gate_off)
      wclk_reg <= 1'b0;
    else if (match)
      wclk_reg <= !wclk_reg;
  end

  assign irq       = irq_reg;
  assign watch_clk = wclk_reg;
  assign count     = cnt_reg;

endmodule

/* hw/pit_top.sv */
/*
  Prescaled interval timer top: AXI4-Lite register slave, mode and
  compare registers, prescaler and counter instances.

  Register map (byte address, low ADDR_W bits; one aligned word each):
    0x2C0  interval_gen_mode     read/write, resets to 00H
    0xC7C  interval_gen_compare  read/write, resets to 00H
    0x2D0  status                read only
  Any other word answers SLVERR; reads of it return zero.

  interval_gen_mode fields:
    bit 4     interval_gen_run: 1 counts, 0 stops and loads 01H
    bit 2     watch_clock_gate_off: 1 holds watch_clk low
    bit 1     count_clock_select_hi
    bit 0     count_clock_select_lo
    others    read as zero, writes ignored

  Count clock select codes:
    00  every main clock
    01  every second main clock
    10  every fourth main clock
    11  every eighth main clock

  interval_gen_compare:
    bits 7:0  interval length N in count clock ticks
    00H       treated as 256 ticks

  Status word:
    bits 7:0  current counter value
    bit 8     run bit as seen by the counter
    bit 9     present level of watch_clk

  Byte lane use:
    Only lane 0 carries mode and compare data.
    A write with wstrb[0] low changes nothing and answers OKAY.
    Data bits 31:8 are ignored on writes and read as zero, save status bits 9:8.
    Single-bit updates are done by software read-modify-write.

  Write timing:
    Address and data are taken in either order.
    The register changes one cycle after the later of the two.
    bvalid rises with that change and stands until bready.
    Both readies stay low until the response is taken.

  Read timing:
    rvalid rises one cycle after the address is taken.
    rdata and rresp stand until rready.
    arready stays low until the read answer is taken.
    A read and a write may be under way together.

  Reset state:
    All readies high, bvalid and rvalid low.
    Counter 01H, prescaler and watch_clk cleared.
    The first request may come at the first edge after reset.

  Timer behaviour:
    The prescaler is cleared and the counter held at 01H while run is low.
    The first interval after run rises is one tick short, except with compare 01H (256 ticks),
    since the counter starts from 01H rather than 00H.
    Each later interval lasts N ticks of the count clock.
    The interrupt is a single main clock pulse per match.
    watch_clk toggles on every match unless gated off, so its period is 2N ticks.

  Hazards:
    Select, gate and compare are not locked while running;
    changing them then gives one irregular interval.
    A compare of 01H with the undivided clock matches on
    every cycle, so the interrupt line then stays high.
  Assumes one 100 MHz clock sys_clk and synchronous active-low nrst;
  the watch timer consumes watch_clk on the same clock.
*/
// Implementation choice: the AXI4-Lite interface to the registers.
`timescale 1ns/10ps
module pit_top
#(
  parameter int ADDR_W = 12
)
(
  input  wire logic              sys_clk,
  input  wire logic              nrst,
  input  wire logic [ADDR_W-1:0] s_axi_awaddr,
  input  wire logic              s_axi_awvalid,
  output logic                   s_axi_awready,
  input  wire logic [31:0]       s_axi_wdata,
  input  wire logic [3:0]        s_axi_wstrb,
  input  wire logic              s_axi_wvalid,
  output logic                   s_axi_wready,
  output logic [1:0]             s_axi_bresp,
  output logic                   s_axi_bvalid,
  input  wire logic              s_axi_bready,
  input  wire logic [ADDR_W-1:0] s_axi_araddr,
  input  wire logic              s_axi_arvalid,
  output logic                   s_axi_arready,
  output logic [31:0]            s_axi_rdata,
  output logic [1:0]             s_axi_rresp,
  output logic                   s_axi_rvalid,
  input  wire logic              s_axi_rready,
  output logic                   interval_gen_irq,
  output logic                   watch_clk
);

  localparam logic [ADDR_W-3:0] MODE_WORD   = pit_pkg::MODE_IDX[ADDR_W-3:0];
  localparam logic [ADDR_W-3:0] CMP_WORD    = pit_pkg::CMP_IDX[ADDR_W-3:0];
  localparam logic [ADDR_W-3:0] STATUS_WORD = pit_pkg::STATUS_IDX[ADDR_W-3:0];
  localparam logic [1:0]        SEL_NONE    = 2'h0;
  localparam logic [1:0]        SEL_MODE    = 2'h1;
  localparam logic [1:0]        SEL_CMP     = 2'h2;
  localparam logic [1:0]        SEL_STATUS  = 2'h3;

  logic [7:0]        interval_gen_mode_reg;
  logic [7:0]        interval_gen_compare_reg;
  logic              awready_reg;
  logic              wready_reg;
  logic              bvalid_reg;
  logic [1:0]        bresp_reg;
  logic              arready_reg;
  logic              rvalid_reg;
  logic [1:0]        rresp_reg;
  logic [31:0]       rdata_reg;
  logic [ADDR_W-1:0] waddr_reg;
  logic [31:0]       wdata_reg;
  logic [3:0]        wstrb_reg;
  logic              do_write;
  logic [1:0]        wsel;
  logic [1:0]        rsel;
  logic [7:0]        count;
  logic              irq_w;
  logic              wclk_w;

  pit_ctrl_if ctrl ();

  ////////////////////////////////////////////////////////////////////////////
  // Address decode shared by the read and write paths
  function automatic logic [1:0] reg_sel(input logic [ADDR_W-1:0] a);
    if (a[ADDR_W-1:2] == MODE_WORD)
      reg_sel = SEL_MODE;
    else if (a[ADDR_W-1:2] == CMP_WORD)
      reg_sel = SEL_CMP;
    else if (a[ADDR_W-1:2] == STATUS_WORD)
      reg_sel = SEL_STATUS;
    else
      reg_sel = SEL_NONE;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Write address channel: one address held until the response is taken
  always_ff @(posedge sys_clk)
  begin
    if (!nrst)
    begin
      awready_reg <= 1'b1;
      waddr_reg   <= '0;
    end
    else if (s_axi_awvalid && awready_reg)
    begin
      awready_reg <= 1'b0;
      waddr_reg   <= s_axi_awaddr;
    end
    else if (bvalid_reg && s_axi_bready)
      awready_reg <= 1'b1;
  end

  // Write data channel, taken independently of the address
  always_ff @(posedge sys_clk)
  begin
    if (!nrst)
    begin
      wready_reg <= 1'b1;
      wdata_reg  <= '0;
      wstrb_reg  <= '0;
    end
    else if (s_axi_wvalid && wready_reg)
    begin
      wready_reg <= 1'b0;
      wdata_reg  <= s_axi_wdata;
      wstrb_reg  <= s_axi_wstrb;
    end
    else if (bvalid_reg && s_axi_bready)
      wready_reg <= 1'b1;
  end

  // Both halves held and no response pending: perform the write once
  assign do_write = !awready_reg && !wready_reg && !bvalid_reg;
  assign wsel     = reg_sel(waddr_reg);

  // Write response; unmapped or read-only words answer SLVERR
  always_ff @(posedge sys_clk)
  begin
    if (!nrst)
    begin
      bvalid_reg <= 1'b0;
      bresp_reg  <= pit_pkg::RESP_OKAY;
    end
    else if (do_write)
    begin
      bvalid_reg <= 1'b1;
      bresp_reg  <= (wsel == SEL_MODE || wsel == SEL_CMP) ? pit_pkg::RESP_OKAY : pit_pkg::RESP_SLVERR;
    end
    else if (bvalid_reg && s_axi_bready)
      bvalid_reg <= 1'b0;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Mode register: byte lane 0, unused bits forced to zero
  always_ff @(posedge sys_clk)
  begin
    if (!nrst)
      interval_gen_mode_reg <= pit_pkg::MODE_RESET;
    else if (do_write && wsel == SEL_MODE && wstrb_reg[0])
      interval_gen_mode_reg <= wdata_reg[7:0] & pit_pkg::MODE_MASK;
  end

  // Compare register: byte lane 0 only
  always_ff @(posedge sys_clk)
  begin
    if (!nrst)
      interval_gen_compare_reg <= pit_pkg::CMP_RESET;
    else if (do_write && wsel == SEL_CMP && wstrb_reg[0])
      interval_gen_compare_reg <= wdata_reg[7:0];
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read channel: answer one cycle after the address is taken
  assign rsel = reg_sel(s_axi_araddr);

  always_ff @(posedge sys_clk)
  begin
    if (!nrst)
    begin
      arready_reg <= 1'b1;
      rvalid_reg  <= 1'b0;
      rresp_reg   <= pit_pkg::RESP_OKAY;
      rdata_reg   <= '0;
    end
    else if (s_axi_arvalid && arready_reg)
    begin
      arready_reg <= 1'b0;
      rvalid_reg  <= 1'b1;
      rresp_reg   <= (rsel == SEL_NONE) ? pit_pkg::RESP_SLVERR : pit_pkg::RESP_OKAY;
      case (rsel)
        SEL_MODE:   rdata_reg <= {24'h000000, interval_gen_mode_reg};
        SEL_CMP:    rdata_reg <= {24'h000000, interval_gen_compare_reg};
        SEL_STATUS: rdata_reg <= {22'h0, wclk_w, ctrl.run, count};
        default:    rdata_reg <= '0;
      endcase
    end
    else if (rvalid_reg && s_axi_rready)
    begin
      rvalid_reg  <= 1'b0;
      arready_reg <= 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Control fields onto the carrier; software keeps select and gate stable while running
  assign ctrl.run      = interval_gen_mode_reg[pit_pkg::RUN_BIT];
  assign ctrl.sel      = {interval_gen_mode_reg[pit_pkg::SEL_HI_BIT],
                          interval_gen_mode_reg[pit_pkg::SEL_LO_BIT]};
  assign ctrl.gate_off = interval_gen_mode_reg[pit_pkg::GATE_OFF_BIT];
  assign ctrl.cmp      = interval_gen_compare_reg;

  pit_prescaler u_pre
  (
    .sys_clk (sys_clk),
    .nrst    (nrst),
    .bus     (ctrl)
  );

  pit_counter u_cnt
  (
    .sys_clk   (sys_clk),
    .nrst      (nrst),
    .bus       (ctrl),
    .irq       (irq_w),
    .watch_clk (wclk_w),
    .count     (count)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Outputs, all from flip-flops
  assign s_axi_awready    = awready_reg;
  assign s_axi_wready     = wready_reg;
  assign s_axi_bvalid     = bvalid_reg;
  assign s_axi_bresp      = bresp_reg;
  assign s_axi_arready    = arready_reg;
  assign s_axi_rvalid     = rvalid_reg;
  assign s_axi_rresp      = rresp_reg;
  assign s_axi_rdata      = rdata_reg;
  assign interval_gen_irq = irq_w;
  assign watch_clk        = wclk_w;

endmodule

/* bench/pit_top_chk.sv */
/*
  Port checker of the interval timer top: bus answers, interrupt pulse
  and watch clock gating. Bound to every pit_top instance.
*/
`timescale 1ns/10ps
module pit_top_chk
#(
  parameter int ADDR_W = 12
)
(
  input wire logic              sys_clk,
  input wire logic              nrst,
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic              s_axi_awvalid,
  input wire logic              s_axi_awready,
  input wire logic [31:0]       s_axi_wdata,
  input wire logic [3:0]        s_axi_wstrb,
  input wire logic              s_axi_wvalid,
  input wire logic              s_axi_wready,
  input wire logic [1:0]        s_axi_bresp,
  input wire logic              s_axi_bvalid,
  input wire logic              s_axi_bready,
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic              s_axi_arvalid,
  input wire logic              s_axi_arready,
  input wire logic [31:0]       s_axi_rdata,
  input wire logic [1:0]        s_axi_rresp,
  input wire logic              s_axi_rvalid,
  input wire logic              s_axi_rready,
  input wire logic              interval_gen_irq,
  input wire logic              watch_clk
);
  localparam logic [31:0] AM = pit_pkg::MODE_IDX << 2;
  localparam logic [31:0] AC = pit_pkg::CMP_IDX << 2;
  localparam logic [31:0] AS = pit_pkg::STATUS_IDX << 2;
  logic [ADDR_W-1:0] aw_q;
  logic [8:0]        w_q;
  logic              bv_q;
  logic [7:0]        mode_sh;
  logic              bad_ar;

  default clocking @(posedge sys_clk); endclocking
  default disable iff (!nrst);

  // Shadow of the mode register, updated when an accepted write answers
  always_ff @(posedge sys_clk)
  begin
    if (s_axi_awvalid && s_axi_awready)
      aw_q <= s_axi_awaddr;
    if (s_axi_wvalid && s_axi_wready)
      w_q <= {s_axi_wstrb[0], s_axi_wdata[7:0]};
    bv_q <= s_axi_bvalid;
    if (!nrst)
      mode_sh <= 8'h00;
    else if (s_axi_bvalid && !bv_q && s_axi_bresp == pit_pkg::RESP_OKAY && aw_q == AM[ADDR_W-1:0] && w_q[8])
      mode_sh <= w_q[7:0] & pit_pkg::MODE_MASK;
  end

  // Read address other than the three aligned register byte addresses
  assign bad_ar = s_axi_araddr != AM[ADDR_W-1:0] && s_axi_araddr != AC[ADDR_W-1:0] && s_axi_araddr != AS[ADDR_W-1:0];

  ////////////////////////////////////////////////////////////////////////////
  sequence ar_take;
    s_axi_arvalid && s_axi_arready;
  endsequence
  sequence aw_w_take;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence

  a_irq_one_pulse: assert property (interval_gen_irq |=> !interval_gen_irq)
    else $error("interrupt longer than one cycle");
  a_irq_needs_run: assert property (!mode_sh[pit_pkg::RUN_BIT] && !$past(mode_sh[pit_pkg::RUN_BIT])
    && !$past(mode_sh[pit_pkg::RUN_BIT], 2) |-> !interval_gen_irq)
    else $error("interrupt while stopped");
  a_wclk_stopped: assert property (!mode_sh[pit_pkg::RUN_BIT] && !$past(mode_sh[pit_pkg::RUN_BIT]) |-> !watch_clk)
    else $error("watch clock runs while stopped");
  a_wclk_gated: assert property (mode_sh[pit_pkg::GATE_OFF_BIT] && $past(mode_sh[pit_pkg::GATE_OFF_BIT])
    && $past(mode_sh[pit_pkg::GATE_OFF_BIT], 2) |-> !watch_clk)
    else $error("watch clock runs while gated");
  a_bresp_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write answer dropped early");
  a_rdata_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata)
    && $stable(s_axi_rresp))
    else $error("read answer dropped early");
  a_read_answer: assert property (ar_take |=> s_axi_rvalid && !s_axi_arready)
    else $error("read not answered next cycle");
  a_write_answer: assert property (aw_w_take |-> ##[1:2] s_axi_bvalid)
    else $error("write not answered");
  a_bad_read: assert property (ar_take and bad_ar |=> s_axi_rresp == pit_pkg::RESP_SLVERR && s_axi_rdata == 32'h0)
    else $error("unmapped read not refused");
  a_mode_upper: assert property (ar_take and s_axi_araddr == AM[ADDR_W-1:0]
    |=> (s_axi_rdata & ~{24'h0, pit_pkg::MODE_MASK}) == 32'h0)
    else $error("mode reserved bits not zero");
endmodule

bind pit_top pit_top_chk #(.ADDR_W(ADDR_W)) chk_u (.sys_clk(sys_clk), .nrst(nrst),
  .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
  .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
  .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
  .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
  .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
  .interval_gen_irq(interval_gen_irq), .watch_clk(watch_clk));

/* bench/pit_watch_model.sv */
/*
  Watch timer stand-in: counts rising edges of the supplied clock and
  the main clock cycles between the last two. Same clock as the timer.
*/
`timescale 1ns/10ps
module pit_watch_model
(
  input  wire logic sys_clk,
  input  wire logic nrst,
  input  wire logic watch_clk,
  output int        edges,
  output int        period
);
  logic prev;
  int   since;

  // Edge count and period of the watch clock
  always_ff @(posedge sys_clk)
  begin
    prev <= watch_clk;
    if (!nrst)
    begin
      edges <= 0;
      since <= 0;
      period <= 0;
    end
    else if (watch_clk && !prev)
    begin
      edges <= edges + 1;
      period <= since + 1;
      since <= 0;
    end
    else
      since <= since + 1;
  end
endmodule

/* bench/tb_prescaled_interval_timer.sv */
/*
  Self-checking bench of the interval timer top: registers over the
  bus, interval and watch clock rates. Needs the checker and watch model.
*/
`timescale 1ns/10ps
module tb_prescaled_interval_timer;
  localparam logic [31:0] AM = pit_pkg::MODE_IDX << 2;
  localparam logic [31:0] AC = pit_pkg::CMP_IDX << 2;
  localparam logic [31:0] AS = pit_pkg::STATUS_IDX << 2;
  localparam int          WATCH_FX_HZ = 8000000; // Nominal main clock for the setup arithmetic
  logic        sys_clk = 1'b0;
  logic        nrst = 1'b0;
  logic [11:0] awaddr = 12'h000;
  logic [11:0] araddr = 12'h000;
  logic [31:0] wdata = 32'h0;
  logic [3:0]  wstrb = 4'h0;
  logic        awvalid = 1'b0;
  logic        wvalid = 1'b0;
  logic        bready = 1'b0;
  logic        arvalid = 1'b0;
  logic        rready = 1'b0;
  logic        awready, wready, bvalid, arready, rvalid, irq, watch_clk;
  logic [1:0]  bresp, rresp;
  logic [31:0] rdata;
  int          failures = 0;
  int          n_tests = 0;
  int          cyc = 0;
  int          edges, period;

  always #5 sys_clk = ~sys_clk;

  pit_top dut_u (.sys_clk(sys_clk), .nrst(nrst), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .interval_gen_irq(irq),
    .watch_clk(watch_clk));
  pit_watch_model wm_u (.sys_clk(sys_clk), .nrst(nrst), .watch_clk(watch_clk), .edges(edges), .period(period));

  ////////////////////////////////////////////////////////////////////////////
  task automatic summarize;
    $display("checks %0d mismatches %0d", n_tests, failures);
    if (failures == 0 && n_tests > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  // Hang guard
  always @(posedge sys_clk)
  begin
    cyc++;
    if (cyc == 30000)
    begin
      failures++;
      summarize();
    end
  end

  task automatic chk_v(logic [31:0] got, logic [31:0] exp);
    n_tests++;
    if (got !== exp)
    begin
      failures++;
      $display("FAIL %0t value %h expected %h", $time, got, exp);
    end
  endtask

  task automatic chk_n(int got, int exp);
    n_tests++;
    if (got != exp)
    begin
      failures++;
      $display("FAIL %0t count %0d expected %0d", $time, got, exp);
    end
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // Bus write: address and data offered together, each released once taken
  task automatic wr(logic [31:0] a, logic [31:0] d, logic [3:0] s, output logic [1:0] r);
    r = 2'h1;
    @(posedge sys_clk);
    awaddr <= a[11:0];
    wdata <= d;
    wstrb <= s;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do
    begin
      @(posedge sys_clk);
      if (awvalid && awready)
        awvalid <= 1'b0;
      if (wvalid && wready)
        wvalid <= 1'b0;
      if (bvalid === 1'b1)
        r = bresp;
    end
    while (bvalid !== 1'b1);
    bready <= 1'b0;
  endtask

  task automatic w8(logic [31:0] a, logic [31:0] d);
    logic [1:0] r;
    wr(a, d, 4'hF, r);
  endtask

  // Bus read: request held until taken, ready held until the answer
  task automatic rd(logic [31:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge sys_clk);
    araddr <= a[11:0];
    arvalid <= 1'b1;
    rready <= 1'b1;
    do
    begin
      @(posedge sys_clk);
      if (arvalid && arready)
        arvalid <= 1'b0;
      d = rdata;
      r = rresp;
    end
    while (rvalid !== 1'b1);
    rready <= 1'b0;
  endtask

  // Cycles until the next interrupt pulse
  task automatic wait_irq(output int n);
    n = 0;
    do
    begin
      @(posedge sys_clk);
      n++;
    end
    while (irq !== 1'b1 && n < 2000);
  endtask

  ////////////////////////////////////////////////////////////////////////////
  task automatic t_regs;
    logic [31:0] d;
    logic [1:0]  r;
    rd(AM, d, r);
    chk_v(d, 32'h00);
    rd(AC, d, r);
    chk_v(d, 32'h00);
    w8(AM, 32'hFFFFFFEF);
    rd(AM, d, r);
    chk_v(d, 32'h07);
    w8(AC, 32'h123456A5);
    wr(AC, 32'h5A, 4'hE, r);
    chk_v(r, pit_pkg::RESP_OKAY);
    rd(AC, d, r);
    chk_v(d, 32'hA5);
    wr(32'h004, 32'h1, 4'hF, r);
    chk_v(r, pit_pkg::RESP_SLVERR);
    rd(32'h004, d, r);
    chk_v(r, pit_pkg::RESP_SLVERR);
    chk_v(d, 32'h0);
    wr(AS, 32'h0, 4'hF, r);
    chk_v(r, pit_pkg::RESP_SLVERR);
    w8(AM, 32'h0);
  endtask

  task automatic t_interval(int sel, int n);
    int          g, tk;
    logic [31:0] d;
    logic [1:0]  r;
    tk = (1 << sel) * (n == 0 ? 256 : n);
    w8(AC, n);
    w8(AM, sel);
    w8(AM, sel | 32'h10);
    wait_irq(g);
    chk_n(int'(g <= tk + 4), 1);
    repeat (4)
    begin
      wait_irq(g);
      chk_n(g, tk);
    end
    chk_n(period, 2 * tk);
    w8(AM, sel);
    repeat (20) @(posedge sys_clk);
    rd(AS, d, r);
    chk_v({d[9:0], watch_clk}, {2'b00, pit_pkg::CNT_STOPPED, 1'b0});
  endtask

  task automatic t_gate;
    int g, e;
    w8(AC, 2);
    w8(AM, 32'h04);
    w8(AM, 32'h14);
    e = edges;
    repeat (3) wait_irq(g);
    chk_n(g, 2);
    chk_n(edges, e);
    w8(AM, 32'h04);
  endtask

  // Watch clock setup derived as software would from the main clock
  task automatic t_watch_setup;
    int n, m;
    n = WATCH_FX_HZ / 65536;
    m = 0;
    while (n % 2 == 0 && m < 3)
    begin
      n = n / 2;
      m++;
    end
    t_interval(m, n);
  endtask

  ////////////////////////////////////////////////////////////////////////////
  initial
  begin
    repeat (4) @(posedge sys_clk);
    nrst <= 1'b1;
    t_regs();
    for (int s = 0; s < 4; s++)
      t_interval(s, 3);
    t_interval(0, 0);
    t_gate();
    t_watch_setup();
    summarize();
  end
endmodule
